// ===== monitor_irq_mask_and_temp_mode.sv
// Second interrupt mask and status registers of a hardware monitor, with
// the two temperature interrupt modes and the interrupt output.
// Assumes all inputs synchronous to clk_sys; conv_done pulses once per
// completed conversion with the temperature compare levels valid.
`timescale 1ns/1ps
`include "monitor_defines.svh"

module monitor_irq_mask_and_temp_mode (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial bus pins.
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Conversion results, index 0 hot limit, index 1 shutdown limit.
	input wire logic conv_done,
	input wire logic [1:0] temp_above_hot,
	input wire logic [1:0] temp_below_hyst,
	// Other fault sources, high while the fault is present.
	input wire logic board_temp_input,
	input wire logic tach_channel_a,
	input wire logic tach_channel_b,
	input wire logic chassis_intrusion,
	// Interrupt output, active low.
	output logic irq_n
);

	logic [7:0] irq_mask_second_r;
	logic [5:0] status_r;
	logic [5:0] status_nxt;
	logic [1:0] temp_high_r;
	logic [5:0] set_v;
	logic [7:0] reg_ptr;
	logic [7:0] wr_data;
	logic wr_stb;
	logic rd_stb;
	logic sda_oe_int;

	// Register decode and read data.
	wire ptr_status = (reg_ptr == `REG_IRQ_STATUS_SECOND);
	wire ptr_mask = (reg_ptr == `REG_IRQ_MASK_SECOND);
	wire mask_wr = wr_stb & ptr_mask;
	wire status_rd = rd_stb & ptr_status;
	wire [5:0] unmasked = status_r & ~irq_mask_second_r[5:0];
	wire [7:0] rd_data = ptr_status ? {2'b00, status_r}
		: ptr_mask ? irq_mask_second_r : 8'h00;

	serial_reg_port u_port (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe(sda_oe_int),
		.reg_ptr(reg_ptr),
		.wr_data(wr_data),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.rd_data(rd_data)
	);

	// Plain fault sources set their flag whenever present.
	assign set_v[`BIT_BOARD_TEMP_INPUT] = board_temp_input;
	assign set_v[`BIT_TACH_CHANNEL_A] = tach_channel_a;
	assign set_v[`BIT_TACH_CHANNEL_B] = tach_channel_b;
	assign set_v[`BIT_CHASSIS_INTRUSION] = chassis_intrusion;

	// One temperature channel per limit; both share the same mode logic.
	for (genvar c = 0; c < 2; c++) begin : g_temp
		localparam int B = (c == 0) ? `BIT_HOT_TEMP : `BIT_OVERTEMP_SHUTDOWN;
		wire one_time = irq_mask_second_r[`BIT_MODE_FIRST + c];
		wire hot = temp_above_hot[c];
		wire cool = temp_below_hyst[c];
		wire hi = temp_high_r[c];
		wire set_default = hot | (hi & ~cool);
		wire set_once = (~hi & hot) | (hi & cool);
		assign set_v[B] = conv_done & (one_time ? set_once : set_default);

		// The high state holds from the hot crossing to the hysteresis fall.
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				temp_high_r[c] <= 1'b0;
			end else if (conv_done) begin
				temp_high_r[c] <= hot | (hi & ~cool);
			end
		end
	end

	// read clears
	// A new event in the reading cycle wins over the clear; one in the cycle before it is cleared unread.
	assign status_nxt = (status_r & ~{`NUM_FLAGS{status_rd}}) | set_v;

	// power-on clear
	// Mask and status registers.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_mask_second_r <= `IRQ_MASK_SECOND_RST;
			status_r <= `IRQ_STATUS_SECOND_RST;
		end else begin
			status_r <= status_nxt;
			if (mask_wr) begin
				irq_mask_second_r <= wr_data;
			end
		end
	end

	// masked interrupt
	// Outputs are registered; the data line is only ever pulled low.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_n <= 1'b1;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			irq_n <= ~(|unmasked);
			sda_out <= 1'b0;
			sda_oe <= sda_oe_int;
		end
	end

	// Assertions.
	property p_reset_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> irq_mask_second_r == 8'h00 && status_r == 6'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("mask or status not clear after reset");

	property p_masked_quiet;
		@(posedge clk_sys) disable iff (!rst_n)
		(unmasked == 6'h00) |=> irq_n;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet)
		else $error("interrupt driven with every flag masked");

	property p_unmasked_irq;
		@(posedge clk_sys) disable iff (!rst_n)
		(|unmasked) |=> !irq_n;
	endproperty
	a_unmasked_irq: assert property (p_unmasked_irq)
		else $error("unmasked flag failed to drive interrupt");

	sequence s_hot_conv(int c);
		conv_done && temp_above_hot[c];
	endsequence

	// The hot flag must also be unmasked, or the output rightly stays high.
	property p_default_raise;
		@(posedge clk_sys) disable iff (!rst_n)
		((!irq_mask_second_r[6] && !irq_mask_second_r[0]) and s_hot_conv(0))
			|=> status_r[0] ##1 !irq_n;
	endproperty
	a_default_raise: assert property (p_default_raise)
		else $error("default mode missed hot interrupt");

	property p_default_repeat;
		@(posedge clk_sys) disable iff (!rst_n)
		!irq_mask_second_r[7] && conv_done && temp_high_r[1]
			&& !temp_below_hyst[1] |=> status_r[5];
	endproperty
	a_default_repeat: assert property (p_default_repeat)
		else $error("default mode did not re-raise shutdown flag");

	property p_once_no_repeat;
		@(posedge clk_sys) disable iff (!rst_n)
		irq_mask_second_r[6] && conv_done && temp_high_r[0]
			&& !temp_below_hyst[0] && !status_r[0] |=> !status_r[0];
	endproperty
	a_once_no_repeat: assert property (p_once_no_repeat)
		else $error("one-time mode repeated hot interrupt");

	property p_once_hyst;
		@(posedge clk_sys) disable iff (!rst_n)
		irq_mask_second_r[6] && conv_done && temp_high_r[0]
			&& temp_below_hyst[0] |=> status_r[0] && !temp_high_r[0];
	endproperty
	a_once_hyst: assert property (p_once_hyst)
		else $error("one-time mode missed hysteresis interrupt");

	property p_once_silent;
		@(posedge clk_sys) disable iff (!rst_n)
		irq_mask_second_r[6] && conv_done && !temp_high_r[0]
			&& !temp_above_hot[0] && !status_r[0] |=> !status_r[0];
	endproperty
	a_once_silent: assert property (p_once_silent)
		else $error("one-time mode raised without hot crossing");

	property p_read_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		status_rd && !set_v[0] && !set_v[5] |=> !status_r[0] && !status_r[5];
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("status read did not clear temperature flags");

	property p_status_view;
		@(posedge clk_sys) disable iff (!rst_n)
		ptr_status |-> rd_data == {2'b00, status_r};
	endproperty
	a_status_view: assert property (p_status_view)
		else $error("status register read data mismatch");

	// A host write must reach every mask and mode bit on the next edge.
	property p_mask_write;
		@(posedge clk_sys) disable iff (!rst_n)
		mask_wr |=> irq_mask_second_r == $past(wr_data);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask register write did not land");

endmodule

// ===== monitor_defines.svh
// Constants for the monitor interrupt block: register offsets, field
// positions, reset values and the serial slave address.
// Assumes inclusion by bare name from every file that needs them.
`ifndef MONITOR_DEFINES_SVH
`define MONITOR_DEFINES_SVH

// Register pointer values on the serial bus.
`define REG_IRQ_STATUS_SECOND 8'h02
`define REG_IRQ_MASK_SECOND 8'h04

// Reset values.
`define IRQ_MASK_SECOND_RST 8'h00
`define IRQ_STATUS_SECOND_RST 6'h00

// Status and mask bit positions.
`define BIT_HOT_TEMP 0
`define BIT_BOARD_TEMP_INPUT 1
`define BIT_TACH_CHANNEL_A 2
`define BIT_TACH_CHANNEL_B 3
`define BIT_CHASSIS_INTRUSION 4
`define BIT_OVERTEMP_SHUTDOWN 5
`define BIT_MODE_FIRST 6
`define NUM_FLAGS 6

// Seven-bit serial slave address of the device.
`define SLAVE_ADDR 7'h2D

// Bits per serial byte, counted before the acknowledge slot.
`define BITS_PER_BYTE 4'h8

`endif

// ===== monitor_pkg.sv
// Types shared by the monitor interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package monitor_pkg;

	// Serial slave sequencing states.
	typedef enum logic [3:0] {
		SER_IDLE,
		SER_ADDR,
		SER_ADDR_ACK,
		SER_PTR,
		SER_PTR_ACK,
		SER_WDATA,
		SER_WDATA_ACK,
		SER_RDATA,
		SER_RDATA_ACK
	} ser_state_t;

endpackage

// ===== serial_reg_port.sv
// Two-wire serial slave that turns bus traffic into register strobes.
// Assumes scl and sda inputs are already synchronous to clk_sys.
`timescale 1ns/1ps
`include "monitor_defines.svh"

module serial_reg_port (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial pins.
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe,
	// Register side.
	output logic [7:0] reg_ptr,
	output logic [7:0] wr_data,
	output logic wr_stb,
	output logic rd_stb,
	input wire logic [7:0] rd_data
);

	monitor_pkg::ser_state_t state_r;
	logic scl_q;
	logic sda_q;
	logic [7:0] shift_r;
	logic [3:0] cnt_r;
	logic rw_r;
	logic mack_r;

	// Bus events are seen as edges between successive samples.
	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;
	wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
	wire byte_done = (cnt_r == `BITS_PER_BYTE);
	wire addr_hit = (shift_r[7:1] == `SLAVE_ADDR);
	wire [2:0] tx_idx = 3'h7 - cnt_r[2:0];

	// Pin history for edge detection.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// Slave sequencer; SDA changes only while SCL is low.
	always_ff @(posedge clk_sys) begin
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		if (!rst_n) begin
			state_r <= monitor_pkg::SER_IDLE;
			shift_r <= 8'h00;
			cnt_r <= 4'h0;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe <= 1'b0;
			reg_ptr <= 8'h00;
			wr_data <= 8'h00;
		end else if (start_cond) begin
			state_r <= monitor_pkg::SER_ADDR;
			cnt_r <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop_cond) begin
			state_r <= monitor_pkg::SER_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state_r)
			monitor_pkg::SER_ADDR,
			monitor_pkg::SER_PTR,
			monitor_pkg::SER_WDATA: begin
				if (scl_rise) begin
					shift_r <= {shift_r[6:0], sda_in};
					cnt_r <= cnt_r + 4'h1;
				end else if (scl_fall && byte_done) begin
					sda_oe <= 1'b1;
					if (state_r == monitor_pkg::SER_ADDR) begin
						rw_r <= shift_r[0];
						sda_oe <= addr_hit;
						state_r <= addr_hit ? monitor_pkg::SER_ADDR_ACK
							: monitor_pkg::SER_IDLE;
					end else if (state_r == monitor_pkg::SER_PTR) begin
						reg_ptr <= shift_r;
						state_r <= monitor_pkg::SER_PTR_ACK;
					end else begin
						wr_data <= shift_r;
						wr_stb <= 1'b1;
						state_r <= monitor_pkg::SER_WDATA_ACK;
					end
				end
			end
			monitor_pkg::SER_ADDR_ACK,
			monitor_pkg::SER_PTR_ACK,
			monitor_pkg::SER_WDATA_ACK: begin
				if (scl_fall) begin
					cnt_r <= 4'h0;
					sda_oe <= 1'b0;
					if (state_r == monitor_pkg::SER_ADDR_ACK && rw_r) begin
						shift_r <= rd_data;
						rd_stb <= 1'b1;
						sda_oe <= ~rd_data[7];
						state_r <= monitor_pkg::SER_RDATA;
					end else if (state_r == monitor_pkg::SER_ADDR_ACK) begin
						state_r <= monitor_pkg::SER_PTR;
					end else begin
						state_r <= monitor_pkg::SER_WDATA;
					end
				end
			end
			monitor_pkg::SER_RDATA: begin
				if (scl_rise) begin
					cnt_r <= cnt_r + 4'h1;
				end else if (scl_fall && byte_done) begin
					sda_oe <= 1'b0;
					state_r <= monitor_pkg::SER_RDATA_ACK;
				end else if (scl_fall) begin
					sda_oe <= ~shift_r[tx_idx];
				end
			end
			monitor_pkg::SER_RDATA_ACK: begin
				// The same pointer is re-read while the master acknowledges.
				if (scl_rise) begin
					mack_r <= ~sda_in;
				end else if (scl_fall && mack_r) begin
					cnt_r <= 4'h0;
					shift_r <= rd_data;
					rd_stb <= 1'b1;
					sda_oe <= ~rd_data[7];
					state_r <= monitor_pkg::SER_RDATA;
				end else if (scl_fall) begin
					state_r <= monitor_pkg::SER_IDLE;
				end
			end
			default: begin
				state_r <= monitor_pkg::SER_IDLE;
			end
			endcase
		end
	end

endmodule

// ===== serial_host.sv
// Bit-level host model for the two-wire register bus.
// Assumes the device pulls the data line low through dev_oe.
`timescale 1ns/1ps
`include "monitor_defines.svh"
module serial_host (
	// Clock.
	input wire logic clk_sys,
	// Device pull-down.
	input wire logic dev_oe,
	// Bus pins.
	output logic scl,
	output logic sda
);
	logic pull_r = 1'b0;
	int ph = 5;
	// Pull-up on the wire: high unless a party pulls it low.
	assign sda = ~(pull_r | dev_oe);
	initial scl = 1'b1;
	// Waits n edges, then steps just off the edge.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Data moves only while the clock is low, so no false framing.
	task automatic bit_io(input logic b, output logic s);
		scl = 1'b0;
		tick(1);
		pull_r = ~b;
		tick(ph);
		scl = 1'b1;
		tick(ph);
		s = sda;
	endtask
	// Start is a=0 b=1, stop is a=1 b=0, both with the clock high.
	task automatic frame(input logic a, input logic b);
		scl = 1'b0;
		tick(1);
		pull_r = a;
		tick(ph);
		scl = 1'b1;
		tick(ph);
		pull_r = b;
		tick(ph);
	endtask
	// One byte out or in, then the acknowledge slot.
	task automatic xfer(input logic [7:0] d, input logic k,
		output logic [7:0] q);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(k, s);
	endtask
	// Register write: address, pointer, data.
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		frame(1'b0, 1'b1);
		xfer({`SLAVE_ADDR, 1'b0}, 1'b1, q);
		xfer(p, 1'b1, q);
		xfer(d, 1'b1, q);
		frame(1'b1, 1'b0);
	endtask
	// Register read: set pointer, repeated start, one byte, no ack.
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] q;
		frame(1'b0, 1'b1);
		xfer({`SLAVE_ADDR, 1'b0}, 1'b1, q);
		xfer(p, 1'b1, q);
		frame(1'b0, 1'b1);
		xfer({`SLAVE_ADDR, 1'b1}, 1'b1, q);
		xfer(8'hFF, 1'b1, d);
		frame(1'b1, 1'b0);
	endtask
endmodule

// ===== monitor_irq_mask_and_temp_mode_tb.sv
// Self-checking bench for the monitor interrupt block.
// Assumes serial_host and the design files are compiled first.
`timescale 1ns/1ps
`include "monitor_defines.svh"
module monitor_irq_mask_and_temp_mode_tb;
	logic clk_sys, rst_n, conv_done, scl, sda, sda_oe, sda_out, irq_n;
	logic [1:0] above, below, hold_r;
	logic [3:0] fault;
	logic [7:0] q, mask_r;
	logic [5:0] st_r;
	logic [7:0] corner [4] = '{8'h00, 8'h3F, 8'hC0, 8'hFF};
	int err_total = 0;
	int samples_checked = 0;
	int seed = 46;

	monitor_irq_mask_and_temp_mode DUT (.clk_sys(clk_sys), .rst_n(rst_n),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.conv_done(conv_done), .temp_above_hot(above),
		.temp_below_hyst(below), .board_temp_input(fault[0]),
		.tach_channel_a(fault[1]), .tach_channel_b(fault[2]),
		.chassis_intrusion(fault[3]), .irq_n(irq_n));
	serial_host host (.clk_sys(clk_sys), .dev_oe(sda_oe), .scl(scl),
		.sda(sda));

	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Next flag of one channel; one-time mode reports only crossings.
	function automatic logic tflag(logic one, logic h, logic a, logic b);
		return one ? ((!h & a) | (h & b)) : (a | (h & !b));
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One conversion with random levels and a one-cycle fault burst.
	task automatic step();
		logic [3:0] f;
		@(posedge clk_sys);
		#1;
		above = 2'($random(seed));
		below = 2'($random(seed)) & ~above;
		f = 4'($random(seed));
		fault = f;
		conv_done = 1'b1;
		@(posedge clk_sys);
		#1;
		conv_done = 1'b0;
		fault = 4'h0;
		st_r[0] = st_r[0] | tflag(mask_r[6], hold_r[0], above[0], below[0]);
		st_r[5] = st_r[5] | tflag(mask_r[7], hold_r[1], above[1], below[1]);
		st_r[4:1] = st_r[4:1] | f;
		hold_r = above | (hold_r & ~below);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({7'h0, irq_n}, {7'h0, ~|(st_r & ~mask_r[5:0])});
	endtask

	// Main sequence: corner masks first, then random ones.
	initial begin
		rst_n = 1'b0;
		conv_done = 1'b0;
		above = 2'b00;
		below = 2'b00;
		fault = 4'h0;
		hold_r = 2'b00;
		st_r = 6'h00;
		repeat (20) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		host.rd(`REG_IRQ_MASK_SECOND, q);
		chk(q, `IRQ_MASK_SECOND_RST);
		chk({7'h0, irq_n}, 8'h01);
		host.rd(`REG_IRQ_STATUS_SECOND, q);
		chk(q, {2'b00, `IRQ_STATUS_SECOND_RST});
		for (int i = 0; i < 16; i++) begin
			mask_r = i < 4 ? corner[i] : 8'($random(seed));
			host.ph = 3 + i % 4;
			host.wr(`REG_IRQ_MASK_SECOND, mask_r);
			host.rd(`REG_IRQ_MASK_SECOND, q);
			chk(q, mask_r);
			repeat (4) step();
			host.rd(`REG_IRQ_STATUS_SECOND, q);
			chk(q, {2'b00, st_r});
			st_r = 6'h00;
			chk({7'h0, irq_n}, 8'h01);
		end
		host.rd(8'h07, q);
		chk(q, 8'h00);
		chk({7'h0, sda_out}, 8'h00);
		stop_test();
	end

	// Watchdog; the run needs about 0.39 ms, so this allows about three times.
	initial begin
		#1_200_000;
		err_total++;
		stop_test();
	end
endmodule
